// ### rtl/rlh_link_retry.sv
/*
 * Link-level retry engine: transmit history, sequence counters,
 * acknowledgement through NOP words, check-code validation, stomping,
 * retry handshake and replay.
 * Assumes the peer runs the same protocol, launches link words on rising
 * link clock edges, and that configuration inputs are on ref_clk.
 */
`timescale 1ns/1ns

// Summary of operation
// - Retry mode is latched only at warm reset; link stop never changes it.
// - Every received word is checked; a failure drops it and, in retry mode, starts retry.
// - Replay resends from the first unacknowledged packet through the rest.
// - Failed attempts past a limit below 8 flag unrecoverable, raising flood or interrupt.
// - In retry mode periodic check slots stay empty in the stream.
// - A stomped packet carries the inverted correct check code.
// - Stomp only validated-timing commands with credit, as flagged by user.
// - Stomping only on links in retry mode; info words never stomped.
// - Stomped arrivals drop silently, freeing their credit, no retry.
// - No expectation that a stomped command is ever sent again.
// - Sent count clears on reset, holds across retry, counts real packets.
// - Accepted count clears on reset, counts validated non-info packets.
// - Accepted count rises no later than the packet's buffer release.
// - Every NOP carries the current accepted count.
// - History stores packet with its count; no stomp or info; reset flushes.
// - Packets that do not fit free history space are withheld.
// - Returned count at or past an entry's count removes that entry.
// - Never more than 128 packets outstanding unacknowledged.
// - First packet after reset is number 1; no embedding is done.
// - Packets are never embedded inside data packets.
// - Replay keeps order; replay completes before new packets go.
// - Reconnect: send NOPs, await peer NOP, replay from its count plus one.
// - Retry zeroes every receive credit so they are advertised anew.
module rlh_link_retry
   import rlh_pkg::*;
(
   input  wire logic                ref_clk,
   input  wire logic                srst,
   input  wire logic                link_clk,
   input  wire logic                warm_reset,
   input  wire logic                link_stop_request,
   input  wire rlh_word_s           link_rx_word,
   output logic                     link_tx_word_valid,
   output rlh_word_s                link_tx_word,
   input  wire logic                retry_mode_enable,
   input  wire logic [ATT_W-1:0]    retry_attempt_limit,
   input  wire logic                flood_enable,
   input  wire logic                interrupt_enable,
   input  wire logic                tx_valid,
   output logic                     tx_ready,
   input  wire logic [PAY_W-1:0]    tx_payload,
   input  wire logic                tx_stomp,
   output logic                     rx_valid,
   output logic [PAY_W-1:0]         rx_payload,
   output logic                     credit_release,
   output logic [CREDIT_W-1:0]      rx_credit_count,
   output logic                     retry_mode_active,
   output logic                     retry_active,
   output logic                     unrecoverable_error,
   output logic                     sync_flood,
   output logic                     error_interrupt,
   output logic [SEQ_W-1:0]         tx_sent_packet_count,
   output logic [SEQ_W-1:0]         rx_accepted_packet_count
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);

   // =====================================================================
   // Pin synchronisers and link edge detection
   logic [1:0]     lclk_sync_reg;
   logic [1:0]     warm_sync_reg;
   logic [1:0]     stop_sync_reg;
   rlh_word_s      rx_s1_reg;
   rlh_word_s      rx_s2_reg;
   logic           lclk_prev_reg;
   logic           beat_rise;
   logic           beat_fall;
   logic           clr;
   logic           stop;

   always_ff @(posedge ref_clk) begin
      lclk_sync_reg <= {lclk_sync_reg[0], link_clk};
      warm_sync_reg <= {warm_sync_reg[0], warm_reset};
      stop_sync_reg <= {stop_sync_reg[0], link_stop_request};
      rx_s1_reg     <= link_rx_word;
      rx_s2_reg     <= rx_s1_reg;
      lclk_prev_reg <= lclk_sync_reg[1];
   end

   // Receive words are taken on the falling edge, half a link period after
   // the peer launched them, so the multi-bit sample is settled.
   assign beat_rise = lclk_sync_reg[1] & ~lclk_prev_reg;
   assign beat_fall = ~lclk_sync_reg[1] & lclk_prev_reg;
   assign clr  = srst | warm_sync_reg[1];
   assign stop = stop_sync_reg[1];

   // =====================================================================
   // Retry mode
   logic mode_reg;

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         mode_reg <= 1'b0;
      end else if (warm_sync_reg[1]) begin
         mode_reg <= retry_mode_enable;
      end
   end
   assign retry_mode_active = mode_reg;

   mode_hold_a: assert property (!warm_sync_reg[1] |=> $stable(mode_reg))
      else $error("retry mode changed outside warm reset");

   // =====================================================================
   // Receive validation
   rlh_word_s        rx_w;
   logic [7:0]       rx_good_crc;
   logic             rx_live, rx_good, rx_stomp, rx_bad;
   logic             rx_nop_ok, rx_data_ok, rx_data_stomp, retry_start;
   logic [SEQ_W-1:0] rx_count_reg;
   rlh_state_e       state_reg;

   assign rx_w        = rx_s2_reg;
   assign rx_good_crc = rlh_crc(rx_w);
   assign rx_live  = beat_fall & ~clr & ~stop & (rx_w.kind != RLH_KIND_IDLE);
   assign rx_good  = rx_w.crc == rx_good_crc;
   assign rx_stomp = (rx_w.crc == ~rx_good_crc) & (rx_w.kind == RLH_KIND_DATA);
   // A stomp on an info word is not legal, so it counts as corruption.
   assign rx_bad        = rx_live & ~rx_good & ~rx_stomp;
   assign rx_nop_ok     = rx_live & rx_good & (rx_w.kind == RLH_KIND_NOP);
   assign rx_data_stomp = rx_live & rx_stomp;
   // Only the next expected number is accepted, so replays never duplicate.
   assign rx_data_ok = rx_live & rx_good & (rx_w.kind == RLH_KIND_DATA)
                     & (rx_w.seq == rx_count_reg + SEQ_STEP);
   assign retry_start = mode_reg & (rx_bad
                      | (rx_live & rx_good & (rx_w.kind == RLH_KIND_RETRY)));

   always_ff @(posedge ref_clk) begin
      if (clr) begin
         rx_count_reg <= SEQ_RESET;
      end else if (rx_data_ok) begin
         rx_count_reg <= rx_count_reg + SEQ_STEP;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         rx_valid   <= 1'b0;
         rx_payload <= '0;
      end else begin
         rx_valid <= rx_data_ok;
         if (rx_data_ok) rx_payload <= rx_w.payload;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (clr || retry_start) begin
         rx_credit_count <= '0;
         credit_release  <= 1'b0;
      end else begin
         credit_release <= rx_data_ok | rx_data_stomp;
         if ((rx_data_ok || rx_data_stomp) && rx_credit_count != CREDIT_MAX)
            rx_credit_count <= rx_credit_count + 8'h01;
      end
   end
   assign rx_accepted_packet_count = rx_count_reg;

   rx_count_a: assert property (rx_data_ok |=>
      rx_valid && rx_count_reg == $past(rx_count_reg) + SEQ_STEP)
      else $error("accepted count not advanced with delivery");
   stomp_rx_a: assert property (rx_data_stomp |-> !retry_start
      ##1 ($stable(rx_count_reg) && credit_release))
      else $error("stomped packet mishandled");

   // =====================================================================
   // Transmit history
   rlh_hist_s          hist_mem [HIST_DEPTH];
   logic [HIST_AW-1:0] head_reg, tail_reg, rp_reg;
   logic [HIST_CW-1:0] hcount_reg, rp_left_reg;
   logic [SEQ_W-1:0]   ack_reg, ack_diff, tx_count_reg;
   logic               acked_head, commit, space_ok;
   logic               take_buf, stomp_eff, replay_step;
   rlh_buf_if          bif ();

   always_ff @(posedge ref_clk) begin
      if (clr) begin
         ack_reg <= SEQ_RESET;
      end else if (rx_nop_ok) begin
         ack_reg <= rx_w.seq;
      end
   end

   // Modulo-256 distance; a clear top bit means ack is at or past the entry.
   assign ack_diff   = ack_reg - hist_mem[head_reg].seq;
   assign acked_head = (hcount_reg != '0) & ~ack_diff[SEQ_W-1];
   assign space_ok   = (hcount_reg < HIST_FULL)
                     & ({3'h0, hcount_reg} < OUTSTANDING_MAX);

   always_ff @(posedge ref_clk) begin
      if (clr) begin
         head_reg   <= '0;
         tail_reg   <= '0;
         hcount_reg <= '0;
      end else begin
         if (commit) tail_reg <= tail_reg + 4'h1;
         if (acked_head) head_reg <= head_reg + 4'h1;
         hcount_reg <= hcount_reg + {4'h0, commit} - {4'h0, acked_head};
      end
   end

   always_ff @(posedge ref_clk) begin
      if (commit)
         hist_mem[tail_reg] <= '{seq: tx_count_reg + SEQ_STEP,
                                 payload: bif.out_data.payload};
   end

   always_ff @(posedge ref_clk) begin
      if (clr) begin
         tx_count_reg <= SEQ_RESET;
      end else if (commit) begin
         tx_count_reg <= tx_count_reg + SEQ_STEP;
      end
   end
   assign tx_sent_packet_count = tx_count_reg;

   hist_bound_a: assert property (hcount_reg <= HIST_FULL)
      else $error("history overfilled");
   sent_count_a: assert property (commit |=>
      tx_count_reg == $past(tx_count_reg) + SEQ_STEP
      && hist_mem[$past(tail_reg)].seq == tx_count_reg)
      else $error("committed entry count mismatch");
   stomp_tx_a: assert property (take_buf && stomp_eff |->
      !commit ##1 $stable(tx_count_reg))
      else $error("stomped packet was committed");

   // =====================================================================
   // Transmit word selection
   rlh_word_s  tx_w;
   logic       tx_beat, slot_hole;
   logic [SLOT_W-1:0] slot_reg;
   logic       announce_reg, nop_sent_reg, peer_nop_reg;

   assign bif.in_valid = tx_valid;
   assign bif.in_data  = '{stomp: tx_stomp, payload: tx_payload};
   assign tx_ready     = bif.in_ready;
   assign bif.out_ready = take_buf;

   rlh_two_entry_buffer u_buf (
      .ref_clk (ref_clk),
      .srst    (srst),
      .port    (bif.buffer)
   );

   assign tx_beat   = beat_rise & ~clr & ~stop;
   assign slot_hole = mode_reg & (slot_reg == SLOT_LAST);
   assign stomp_eff = bif.out_data.stomp & mode_reg;

   always_comb begin
      tx_w         = '{kind: RLH_KIND_IDLE, seq: SEQ_RESET,
                       payload: '0, crc: 8'h00};
      take_buf     = 1'b0;
      commit       = 1'b0;
      replay_step  = 1'b0;
      if (tx_beat && !slot_hole) begin
         if (announce_reg) begin
            tx_w.kind = RLH_KIND_RETRY;
            tx_w.seq  = rx_count_reg;
         end else begin
            tx_w.kind = RLH_KIND_NOP;
            tx_w.seq  = rx_count_reg;
            case (state_reg)
               RLH_REPLAY: begin
                  if (rp_left_reg != '0) begin
                     tx_w.kind    = RLH_KIND_DATA;
                     tx_w.seq     = hist_mem[rp_reg].seq;
                     tx_w.payload = hist_mem[rp_reg].payload;
                     replay_step  = 1'b1;
                  end
               end
               RLH_RUN: begin
                  // No embedding is ever done, so entries retire in order.
                  if (bif.out_valid && (stomp_eff || space_ok)) begin
                     tx_w.kind    = RLH_KIND_DATA;
                     tx_w.seq     = tx_count_reg + SEQ_STEP;
                     tx_w.payload = bif.out_data.payload;
                     take_buf     = 1'b1;
                     commit       = ~stomp_eff;
                  end
               end
               default: begin
               end
            endcase
         end
         tx_w.crc = rlh_crc(tx_w);
         if (take_buf && stomp_eff) tx_w.crc = ~tx_w.crc;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (clr) begin
         link_tx_word       <= '0;
         link_tx_word_valid <= 1'b0;
         slot_reg           <= '0;
      end else if (tx_beat) begin
         link_tx_word       <= tx_w;
         link_tx_word_valid <= tx_w.kind != RLH_KIND_IDLE;
         slot_reg           <= slot_reg + 6'h01;
      end
   end

   slot_hole_a: assert property (tx_beat && slot_hole |=>
      link_tx_word.kind == RLH_KIND_IDLE)
      else $error("reserved slot carried a word");
   nop_ack_a: assert property (tx_beat && tx_w.kind == RLH_KIND_NOP |=>
      link_tx_word.seq == $past(rx_count_reg))
      else $error("NOP lacks accepted count");

   // =====================================================================
   // Retry handshake
   always_ff @(posedge ref_clk) begin
      if (clr) begin
         state_reg    <= RLH_RUN;
         announce_reg <= 1'b0;
         nop_sent_reg <= 1'b0;
         peer_nop_reg <= 1'b0;
         rp_reg       <= '0;
         rp_left_reg  <= '0;
      end else if (retry_start) begin
         state_reg    <= RLH_RECONNECT;
         announce_reg <= 1'b1;
         nop_sent_reg <= 1'b0;
         peer_nop_reg <= 1'b0;
      end else begin
         if (tx_beat && !slot_hole) announce_reg <= 1'b0;
         if (rx_nop_ok) peer_nop_reg <= 1'b1;
         if (replay_step) rp_reg <= rp_reg + 4'h1;
         if (replay_step) rp_left_reg <= rp_left_reg - 5'h01;
         case (state_reg)
            RLH_RECONNECT: begin
               if (tx_w.kind == RLH_KIND_NOP) nop_sent_reg <= 1'b1;
               // Acked entries drain first so replay starts at ack plus one.
               if (peer_nop_reg && nop_sent_reg && !acked_head) begin
                  state_reg <= RLH_REPLAY;
                  rp_reg    <= head_reg;
                  // A full history wraps the pointers, so count instead.
                  rp_left_reg <= hcount_reg;
               end
            end
            RLH_REPLAY: begin
               if (rp_left_reg == '0 && !replay_step) state_reg <= RLH_RUN;
            end
            default: begin
            end
         endcase
      end
   end
   assign retry_active = state_reg != RLH_RUN;

   retry_enter_a: assert property (retry_start |=>
      state_reg == RLH_RECONNECT && rx_credit_count == '0 && announce_reg)
      else $error("retry entry incomplete");
   replay_start_a: assert property ($rose(state_reg == RLH_REPLAY) |->
      rp_reg == head_reg && !acked_head)
      else $error("replay not at first unacked entry");

   // =====================================================================
   // Attempt limit and unrecoverable reporting
   logic [ATT_W-1:0] attempts_reg;
   logic             unrec_reg;

   always_ff @(posedge ref_clk) begin
      if (clr) begin
         attempts_reg <= '0;
         unrec_reg    <= 1'b0;
      end else if (retry_start && attempts_reg != ATTEMPT_STOP) begin
         attempts_reg <= attempts_reg + 4'h1;
         if (attempts_reg >= retry_attempt_limit)
            unrec_reg <= 1'b1;
      end else if (rx_nop_ok && state_reg == RLH_RECONNECT) begin
         attempts_reg <= '0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         sync_flood      <= 1'b0;
         error_interrupt <= 1'b0;
      end else begin
         sync_flood      <= unrec_reg & flood_enable;
         error_interrupt <= unrec_reg & interrupt_enable;
      end
   end
   assign unrecoverable_error = unrec_reg;
endmodule

// ### rtl/rlh_pkg.sv
/*
 * Constants, types and the check code function shared by the link retry
 * history block and its two-entry buffer.
 * Assumes one clock domain; link pins are synchronised by the user module.
 */
package rlh_pkg;

   // =====================================================================
   // Widths and depths
   localparam int SEQ_W       = 8;
   localparam int PAY_W       = 32;
   localparam int HIST_DEPTH  = 16;
   localparam int HIST_AW     = 4;
   localparam int HIST_CW     = 5;
   localparam int ATT_W       = 4;
   localparam int CREDIT_W    = 8;
   localparam int SLOT_W      = 6;

   // =====================================================================
   // Counts and reset values
   localparam logic [SEQ_W-1:0]   SEQ_RESET       = 8'h00;
   localparam logic [SEQ_W-1:0]   SEQ_STEP        = 8'h01;
   localparam logic [HIST_CW-1:0] HIST_FULL       = 5'h10;
   localparam logic [7:0]         OUTSTANDING_MAX = 8'h80;
   localparam logic [ATT_W-1:0]   ATTEMPT_STOP    = 4'h8;
   localparam logic [CREDIT_W-1:0] CREDIT_MAX     = 8'hFF;
   // Beats between reserved periodic check slots.
   localparam logic [SLOT_W-1:0]  SLOT_LAST       = 6'h3F;

   // =====================================================================
   // Link word layout
   typedef enum logic [1:0] {
      RLH_KIND_IDLE,
      RLH_KIND_NOP,
      RLH_KIND_DATA,
      RLH_KIND_RETRY
   } rlh_kind_e;

   typedef struct packed {
      rlh_kind_e          kind;
      logic [SEQ_W-1:0]   seq;
      logic [PAY_W-1:0]   payload;
      logic [7:0]         crc;
   } rlh_word_s;

   typedef struct packed {
      logic               stomp;
      logic [PAY_W-1:0]   payload;
   } rlh_txreq_s;

   typedef struct packed {
      logic [SEQ_W-1:0]   seq;
      logic [PAY_W-1:0]   payload;
   } rlh_hist_s;

   typedef enum logic [1:0] {
      RLH_RUN,
      RLH_RECONNECT,
      RLH_REPLAY
   } rlh_state_e;

   // Byte-folding check code over kind, sequence field and payload.
   function automatic logic [7:0] rlh_crc(input rlh_word_s w);
      rlh_crc = {6'h00, w.kind} ^ w.seq ^ w.payload[7:0]
              ^ w.payload[15:8] ^ w.payload[23:16] ^ w.payload[31:24];
   endfunction

endpackage

// ### rtl/rlh_buf_if.sv
/*
 * Valid/ready stream carrier between the retry block and its buffer.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ns
interface rlh_buf_if;
   import rlh_pkg::*;
   logic       in_valid;
   logic       in_ready;
   rlh_txreq_s in_data;
   logic       out_valid;
   logic       out_ready;
   rlh_txreq_s out_data;

   modport buffer (input in_valid, in_data, out_ready,
                   output in_ready, out_valid, out_data);
   modport user   (output in_valid, in_data, out_ready,
                   input in_ready, out_valid, out_data);
endinterface

// ### rtl/rlh_two_entry_buffer.sv
/*
 * Two-entry FIFO holding transmit requests until the link beat takes them.
 * Assumes a synchronous active-high reset on the same clock as both sides.
 */
`timescale 1ns/1ns
module rlh_two_entry_buffer
   import rlh_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic srst,
   rlh_buf_if.buffer port
);
   rlh_txreq_s mem_reg [2];
   logic       wr_ptr_reg;
   logic       rd_ptr_reg;
   logic [1:0] count_reg;
   logic       push;
   logic       pop;

   assign port.in_ready  = (count_reg != 2'h2);
   assign port.out_valid = (count_reg != 2'h0);
   assign port.out_data  = mem_reg[rd_ptr_reg];
   assign push = port.in_valid & port.in_ready;
   assign pop  = port.out_valid & port.out_ready;

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         count_reg  <= 2'h0;
      end else begin
         if (push) wr_ptr_reg <= ~wr_ptr_reg;
         if (pop) rd_ptr_reg <= ~rd_ptr_reg;
         count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
      end
   end

   always_ff @(posedge ref_clk) begin
      if (push) mem_reg[wr_ptr_reg] <= port.in_data;
   end
endmodule

// ### sim/rlh_peer_model.sv
/* Peer link end: free-running link clock and one word per link beat.
   Assumes the bench calls send_word and that idle beats carry IDLE. */
`timescale 1ns/1ns
module rlh_peer_model
   import rlh_pkg::*;
(
   output logic      link_clk,
   output rlh_word_s link_rx_word
);
   // =====================================================================
   // Clock, check code and word launch
   initial begin
      link_clk = 1'b0;
      link_rx_word = '0;
      #37;
      forever #200 link_clk = ~link_clk;
   end

   function automatic logic [7:0] fold(input rlh_word_s w);
      return {6'h00, w.kind} ^ w.seq ^ w.payload[7:0] ^ w.payload[15:8]
           ^ w.payload[23:16] ^ w.payload[31:24];
   endfunction

   // Mode 0 is a good word, 1 a corrupt check code, 2 a stomped word.
   task automatic send_word(input rlh_kind_e k, input logic [7:0] s,
                            input logic [PAY_W-1:0] p, input int mode);
      rlh_word_s w;
      w = '{k, s, p, 8'h00};
      w.crc = fold(w);
      if (mode == 1) w.crc = w.crc ^ 8'h01;
      if (mode == 2) w.crc = ~w.crc;
      @(posedge link_clk);
      link_rx_word <= w;
      @(posedge link_clk);
      // Idle beats change the payload so a stale word is never reused.
      link_rx_word <= '{RLH_KIND_IDLE, ~s, ~p, 8'h00};
   endtask
endmodule

// ### sim/rlh_link_retry_tb_top.sv
/* Self-checking bench for the link retry engine.
   Assumes the peer model drives the link and the hand-over timing. */
`timescale 1ns/1ns
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
   $display("[ERR] t=%0t got %0h exp %0h", $time, (g), (e)); end end
module rlh_link_retry_tb_top
   import rlh_pkg::*;
;
   logic             ref_clk, srst, warm_reset, link_stop_request;
   logic             retry_mode_enable, tx_valid, tx_stomp, link_clk;
   logic             link_tx_word_valid, tx_ready, rx_valid, credit_release;
   logic             retry_mode_active, retry_active;
   logic             flood_enable, interrupt_enable, unrecoverable_error;
   logic             sync_flood, error_interrupt;
   logic [ATT_W-1:0] retry_attempt_limit;
   logic [PAY_W-1:0] tx_payload, rx_payload, got_pay;
   logic [7:0]       rx_credit_count, acc_rel;
   logic [7:0]       tx_sent_packet_count, rx_accepted_packet_count;
   rlh_word_s        link_rx_word, link_tx_word, w;
   int               mismatches, cmp_count, nv, nc, nr;
   logic [PAY_W-1:0] exp_pay [3] = '{32'hA5C3_0F11, 32'h1234_5678,
                                     32'hFEDC_BA98};

   rlh_peer_model peer (.link_clk, .link_rx_word);
   rlh_link_retry dut (.ref_clk, .srst, .link_clk, .warm_reset,
      .link_stop_request, .link_rx_word, .link_tx_word_valid, .link_tx_word,
      .retry_mode_enable, .retry_attempt_limit, .flood_enable,
      .interrupt_enable, .tx_valid, .tx_ready, .tx_payload, .tx_stomp,
      .rx_valid, .rx_payload, .credit_release, .rx_credit_count,
      .retry_mode_active, .retry_active, .unrecoverable_error,
      .sync_flood, .error_interrupt, .tx_sent_packet_count,
      .rx_accepted_packet_count);

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   // =====================================================================
   // Shared tasks
   task automatic finish_test;
      $display("Compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic guard(input int n);
      if (n > 300) begin
         mismatches++;
         finish_test();
      end
   endtask

   // Words are sampled at the link rise, mid-way through their beat.
   task automatic wait_kind(input rlh_kind_e k);
      int n;
      n = 0;
      do begin
         @(posedge link_clk);
         w = link_tx_word;
         n += 5;
         guard(n);
      end while (!(link_tx_word_valid === 1'b1 && w.kind === k));
   endtask

   task automatic send_tx(input logic [PAY_W-1:0] p, input logic s);
      int n;
      n = 0;
      @(posedge ref_clk);
      tx_valid <= 1'b1;
      tx_payload <= p;
      tx_stomp <= s;
      do begin
         @(negedge ref_clk);
         n++;
         guard(n);
      end while (tx_ready !== 1'b1);
      @(posedge ref_clk);
      tx_valid <= 1'b0;
      tx_stomp <= 1'b0;
   endtask

   task automatic rx_word(input logic [7:0] s, input int mode);
      fork
         peer.send_word(RLH_KIND_DATA, s, 32'h0BAD_F00D, mode);
      join_none
      nv = 0;
      nc = 0;
      nr = 0;
      repeat (40) begin
         @(negedge ref_clk);
         if (rx_valid === 1'b1) begin
            nv++;
            got_pay = rx_payload;
         end
         if (credit_release === 1'b1) begin
            nc++;
            acc_rel = rx_accepted_packet_count;
         end
         if (retry_active === 1'b1) nr++;
      end
   endtask

   // =====================================================================
   // Scenarios
   task automatic s_mode(input logic en);
      @(posedge ref_clk);
      retry_mode_enable <= en;
      warm_reset <= 1'b1;
      repeat (5) @(posedge ref_clk);
      warm_reset <= 1'b0;
      // The enable is sampled until the synchronised warm reset drops.
      repeat (3) @(posedge ref_clk);
      retry_mode_enable <= ~en;
      link_stop_request <= 1'b1;
      repeat (12) @(posedge ref_clk);
      link_stop_request <= 1'b0;
      repeat (6) @(negedge ref_clk);
      `CHK(retry_mode_active, en)
      `CHK(tx_sent_packet_count, 8'h00)
      `CHK(rx_accepted_packet_count, 8'h00)
   endtask

   task automatic s_send;
      send_tx(exp_pay[0], 1'b0);
      wait_kind(RLH_KIND_DATA);
      `CHK(w.seq, 8'h01)
      `CHK(w.payload, exp_pay[0])
      `CHK(w.crc, peer.fold(w))
      send_tx(32'h5555_AAAA, 1'b1);
      wait_kind(RLH_KIND_DATA);
      `CHK(w.crc, ~peer.fold(w))
      `CHK(tx_sent_packet_count, 8'h01)
      rx_word(8'h01, 0);
      `CHK(nv, 1)
      `CHK(got_pay, 32'h0BAD_F00D)
      `CHK(acc_rel, 8'h01)
      rx_word(8'h02, 2);
      `CHK(nv + nr, 0)
      `CHK(nc, 1)
      `CHK(rx_accepted_packet_count, 8'h01)
   endtask

   task automatic s_retry;
      fork
         peer.send_word(RLH_KIND_DATA, 8'h02, 32'h0, 1);
      join_none
      wait_kind(RLH_KIND_RETRY);
      `CHK(retry_active, 1'b1)
      `CHK(rx_credit_count, 8'h00)
      `CHK(unrecoverable_error, 1'b0)
      `CHK(rx_accepted_packet_count, 8'h01)
      send_tx(exp_pay[1], 1'b0);
      send_tx(exp_pay[2], 1'b0);
      @(negedge ref_clk);
      `CHK(tx_ready, 1'b0)
      wait_kind(RLH_KIND_NOP);
      `CHK(w.seq, 8'h01)
      peer.send_word(RLH_KIND_NOP, 8'h00, 32'h0, 0);
      for (int i = 0; i < 3; i++) begin
         wait_kind(RLH_KIND_DATA);
         `CHK(w.seq, 8'(i + 1))
         `CHK(w.payload, exp_pay[i])
      end
      `CHK(retry_active, 1'b0)
      `CHK(tx_sent_packet_count, 8'h03)
   endtask

   task automatic s_slot;
      nc = 0;
      repeat (64) begin
         @(posedge link_clk);
         if (link_tx_word_valid !== 1'b1) nc++;
      end
      `CHK(nc, 1)
   endtask

   task automatic s_unrec;
      @(posedge ref_clk);
      retry_attempt_limit <= 4'h0;
      flood_enable <= 1'b1;
      rx_word(8'h09, 1);
      `CHK(nr > 0, 1'b1)
      `CHK(unrecoverable_error, 1'b1)
      `CHK(sync_flood, 1'b1)
      `CHK(error_interrupt, 1'b0)
   endtask

   initial begin
      srst = 1'b1;
      warm_reset = 1'b0;
      link_stop_request = 1'b0;
      retry_mode_enable = 1'b0;
      tx_valid = 1'b0;
      tx_stomp = 1'b0;
      tx_payload = '0;
      retry_attempt_limit = 4'h8;
      flood_enable = 1'b0;
      interrupt_enable = 1'b0;
      mismatches = 0;
      cmp_count = 0;
      repeat (20) @(posedge ref_clk);
      srst <= 1'b0;
      s_mode(1'b1);
      s_send();
      s_retry();
      s_slot();
      s_unrec();
      s_mode(1'b0);
      finish_test();
   end
endmodule
